// ---- design/prog_map_defs.vh ----
// Purpose: Shared constants for the program-space address mapper
// Assumes: Included by bare name from design files
// Notes: Register indices are local choices for the plain register port
`ifndef PROG_MAP_DEFS_VH
`define PROG_MAP_DEFS_VH
// Register indices on the register port
`define REG_TABLE_PAGE 2'h0
`define REG_READ_PAGE 2'h1
`define REG_STATUS 2'h2
`define REG_FETCH_PC 2'h3
// Reset values
`define TABLE_PAGE_RESET 8'h00
`define READ_PAGE_RESET 10'h000
`define FETCH_PC_RESET 23'h000000
// Field positions
`define EA_MSB 15
`define TABLE_PAGE_SELECT_CFG_BIT 7
`define RPAG_PROG_BIT 9
`define RPAG_HIGH_BIT 8
// Extra cycles for window reads
`define WIN_EXTRA_MOVE 2'h1
`define WIN_EXTRA_OTHER 2'h2
// Access kinds
`define ACC_NONE 3'h0
`define ACC_TBLRD_L 3'h1
`define ACC_TBLRD_H 3'h2
`define ACC_TBLWT_L 3'h3
`define ACC_TBLWT_H 3'h4
`define ACC_DATA_RD 3'h5
`define ACC_DATA_WR 3'h6
`endif

// ---- design/prog_space_mapper.v ----
// Purpose: Address generation from data space into 24-bit program memory
// Assumes: Core gives one access strobe per cycle with kind, EA and flags
// Notes: Outputs are registered; strobes appear one cycle after the request, read data two cycles after
//
// How it works
// [RULE1] Table address is page above 16-bit EA
// [RULE2] Each table page spans 32K program words
// [RULE3] Table page bit 7 selects configuration memory
// [RULE4] Table writes to configuration memory are dropped
// [RULE5] Read page is 10 bits, 16K-word pages
// [RULE6] Window address from page low byte, EA[14:0]
// [RULE7] EA bit 15 ignored; address bit 15 from page
// [RULE8] Read page bit 8 picks upper word
// [RULE9] Window address bit 23 forced to zero
// [RULE10] Window is read only; writes never reach flash
// [RULE11] Fetch address is {0, PC[22:1], 0}
// [RULE12] Program counter steps by two per word
// [RULE13] Low word-mode read returns bits 15:0
// [RULE14] Low byte-mode read picks byte by select
// [RULE15] High word-mode read zeroes phantom byte
// [RULE16] High byte read of phantom byte gives zero
// [RULE17] Only high-word table ops and upper-word window reads reach bits 23:16
// [RULE18] Upper EA with zero page raises address trap
// [RULE19] Window reads add one or two cycles
// [RULE20] Lower EA goes to data memory, page ignored
`include "prog_map_defs.vh"
module prog_space_mapper #(
  parameter PAGE_W = 8,
  parameter RPAGE_W = 10
) (
  input wire ref_clk,
  input wire nrst,
  // Register port
  input wire [1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Access request from the core
  input wire acc_valid,
  input wire [2:0] acc_kind,
  input wire [15:0] effective_address,
  input wire byte_mode,
  input wire byte_sel,
  input wire move_insn,
  input wire in_repeat,
  input wire [15:0] acc_wdata,
  // Instruction fetch control
  input wire pc_advance,
  output reg [23:0] fetch_addr,
  // Program memory side
  output reg [23:0] prog_addr,
  output reg prog_rd,
  output reg prog_wr_low,
  output reg prog_wr_high,
  output reg [15:0] prog_wdata,
  input wire [23:0] prog_rdata,
  // Data memory side
  output reg [15:0] data_addr,
  output reg data_rd,
  output reg data_wr,
  // Results to the core
  output reg [15:0] rd_data,
  output reg rd_valid,
  output reg addr_trap,
  output wire stall
);
  ////////////////////////////////////////////////////////////////////
  // Registers
  reg [PAGE_W-1:0] table_page_select_q; // Table page
  reg [RPAGE_W-1:0] read_window_page_select_q; // Read window page
  reg [22:0] pc_q; // Program counter, bit 0 always zero
  reg cfg_drop_q; // Sticky: a config write was dropped
  reg trap_seen_q; // Sticky: a trap was raised
  reg pend_q; // Read data due this cycle
  reg pend_high_q; // Pending read takes upper half
  reg pend_byte_q;
  reg pend_bsel_q;
  reg [15:0] fmt_out;
  wire [15:0] fmt_w;

  // Window hit when EA upper half and page bit 9 set
  function is_window;
    input [15:0] ea;
    input [9:0] pg;
    begin
      is_window = ea[`EA_MSB] & pg[`RPAG_PROG_BIT];
    end
  endfunction

  wire upper_ea = effective_address[`EA_MSB];
  wire is_tbl_rd = (acc_kind == `ACC_TBLRD_L) | (acc_kind == `ACC_TBLRD_H);
  wire is_tbl_wr = (acc_kind == `ACC_TBLWT_L) | (acc_kind == `ACC_TBLWT_H);
  wire is_data = (acc_kind == `ACC_DATA_RD) | (acc_kind == `ACC_DATA_WR);
  wire win_hit = is_window(effective_address, read_window_page_select_q);
  wire cfg_space = table_page_select_q[`TABLE_PAGE_SELECT_CFG_BIT]; // [RULE3]
  // Page zero in the upper half is invalid
  wire page_zero_trap = acc_valid & is_data & upper_ea &
    (read_window_page_select_q == {RPAGE_W{1'b0}}); // [RULE18]
  // Window read that will go to program memory
  wire win_read = acc_valid & (acc_kind == `ACC_DATA_RD) & win_hit & ~page_zero_trap;

  ////////////////////////////////////////////////////////////////////
  // Register writes, fetch counter, sticky status
  always @(posedge ref_clk) begin
    if (!nrst) begin
      table_page_select_q <= `TABLE_PAGE_RESET;
      read_window_page_select_q <= `READ_PAGE_RESET;
      pc_q <= `FETCH_PC_RESET;
      cfg_drop_q <= 1'b0;
      trap_seen_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `REG_TABLE_PAGE) begin
        table_page_select_q <= reg_wdata[PAGE_W-1:0]; // [RULE2]
      end
      if (reg_wr && reg_addr == `REG_READ_PAGE) begin
        read_window_page_select_q <= reg_wdata[RPAGE_W-1:0]; // [RULE5]
      end
      // Fetch PC: load from port or step by two
      if (reg_wr && reg_addr == `REG_FETCH_PC) begin
        // Port value is a word index, so it lands one bit up
        pc_q <= {6'h00, reg_wdata, 1'b0};
      end else if (pc_advance) begin
        pc_q <= pc_q + 23'h000002; // [RULE12]
      end
      // Status clear by write; a new event wins over the clear
      if (acc_valid && is_tbl_wr && cfg_space) begin
        cfg_drop_q <= 1'b1;
      end else if (reg_wr && reg_addr == `REG_STATUS && reg_wdata[0]) begin
        cfg_drop_q <= 1'b0;
      end
      if (page_zero_trap) begin
        trap_seen_q <= 1'b1;
      end else if (reg_wr && reg_addr == `REG_STATUS && reg_wdata[1]) begin
        trap_seen_q <= 1'b0;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_TABLE_PAGE: reg_rdata <= {8'h00, table_page_select_q};
        `REG_READ_PAGE: reg_rdata <= {6'h00, read_window_page_select_q};
        `REG_STATUS: reg_rdata <= {14'h0000, trap_seen_q, cfg_drop_q};
        default: reg_rdata <= pc_q[16:1];
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Access address generation, registered one cycle
  always @(posedge ref_clk) begin
    if (!nrst) begin
      prog_addr <= 24'h000000;
      prog_rd <= 1'b0;
      prog_wr_low <= 1'b0;
      prog_wr_high <= 1'b0;
      prog_wdata <= 16'h0000;
      data_addr <= 16'h0000;
      data_rd <= 1'b0;
      data_wr <= 1'b0;
      addr_trap <= 1'b0;
      fetch_addr <= 24'h000000;
      pend_q <= 1'b0;
      pend_high_q <= 1'b0;
      pend_byte_q <= 1'b0;
      pend_bsel_q <= 1'b0;
    end else begin
      prog_rd <= 1'b0;
      prog_wr_low <= 1'b0;
      prog_wr_high <= 1'b0;
      data_rd <= 1'b0;
      data_wr <= 1'b0;
      addr_trap <= page_zero_trap; // [RULE18]
      pend_q <= 1'b0;
      fetch_addr <= {1'b0, pc_q[22:1], 1'b0}; // [RULE11]
      if (acc_valid && !stall) begin
        if (is_tbl_rd) begin
          // Table reads run in either space
          prog_addr <= {table_page_select_q, effective_address}; // [RULE1]
          prog_rd <= 1'b1; // [RULE4]
          pend_q <= 1'b1;
          pend_high_q <= (acc_kind == `ACC_TBLRD_H); // [RULE17]
          pend_byte_q <= byte_mode;
          pend_bsel_q <= byte_sel;
        end else if (is_tbl_wr && !cfg_space) begin
          prog_addr <= {table_page_select_q, effective_address}; // [RULE1]
          prog_wr_low <= (acc_kind == `ACC_TBLWT_L); // [RULE17]
          prog_wr_high <= (acc_kind == `ACC_TBLWT_H); // [RULE17]
          prog_wdata <= acc_wdata;
        end else if (is_data && !upper_ea) begin
          // Lower half: page registers play no part
          data_addr <= effective_address; // [RULE20]
          data_rd <= (acc_kind == `ACC_DATA_RD); // [RULE20]
          data_wr <= (acc_kind == `ACC_DATA_WR);
        end else if (win_read) begin
          prog_addr <= {1'b0, read_window_page_select_q[7:0],
            effective_address[14:0]}; // [RULE6] [RULE7] [RULE9]
          prog_rd <= 1'b1;
          pend_q <= 1'b1;
          pend_high_q <= read_window_page_select_q[`RPAG_HIGH_BIT]; // [RULE8]
          pend_byte_q <= byte_mode;
          pend_bsel_q <= byte_sel;
        end else if (is_data && upper_ea && !page_zero_trap) begin
          // Extended data outside the window passes to data memory
          // Window writes never reach program memory
          data_addr <= effective_address; // [RULE10]
          data_rd <= (acc_kind == `ACC_DATA_RD);
          data_wr <= (acc_kind == `ACC_DATA_WR); // [RULE10]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read result formatting; program memory answers combinationally
  word_formatter u_fmt (
    .prog_word(prog_rdata),
    .high_sel(pend_high_q),
    .byte_mode(pend_byte_q),
    .byte_sel(pend_bsel_q),
    .data_out(fmt_w)
  );

  // Read result register
  always @(posedge ref_clk) begin
    if (!nrst) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= pend_q;
      if (pend_q) begin
        rd_data <= fmt_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Window read stall: one extra cycle for moves outside a loop,
  // two for everything else; the loop case is simplified to two
  wire [1:0] extra_cycles = (move_insn && !in_repeat) ?
    `WIN_EXTRA_MOVE : `WIN_EXTRA_OTHER; // [RULE19]
  stall_counter u_stall (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(win_read & ~stall),
    .cycles(extra_cycles),
    .busy(stall)
  );
endmodule // prog_space_mapper

// ---- design/stall_counter.v ----
// Purpose: Count extra instruction cycles for program-window reads
// Assumes: One start pulse per access, ignored while busy
// Notes: busy stays high for exactly the loaded number of cycles
module stall_counter (
  input wire ref_clk,
  input wire nrst,
  input wire start,
  input wire [1:0] cycles,
  output wire busy
);
  reg [1:0] count_q; // Cycles still to wait
  reg [1:0] count_d;
  // Next count
  always @* begin
    count_d = count_q;
    if (count_q != 2'h0) begin
      count_d = count_q - 2'h1;
    end else if (start) begin
      count_d = cycles;
    end
  end
  // Count register
  always @(posedge ref_clk) begin
    if (!nrst) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_d;
    end
  end
  assign busy = (count_q != 2'h0);
endmodule // stall_counter

// ---- design/word_formatter.v ----
// Purpose: Shape a 24-bit program word into a 16-bit data word
// Assumes: Combinational; the caller registers the result
// Notes: The phantom byte above bits 23:16 always reads as zero
module word_formatter (
  input wire [23:0] prog_word,
  input wire high_sel,
  input wire byte_mode,
  input wire byte_sel,
  output reg [15:0] data_out
);
  // Pick low or high half, then byte lane
  always @* begin
    data_out = 16'h0000;
    if (!high_sel) begin
      if (!byte_mode) begin
        data_out = prog_word[15:0]; // [RULE13]
      end else if (byte_sel) begin
        data_out = {8'h00, prog_word[15:8]}; // [RULE14]
      end else begin
        data_out = {8'h00, prog_word[7:0]}; // [RULE14]
      end
    end else begin
      if (!byte_mode) begin
        data_out = {8'h00, prog_word[23:16]}; // [RULE15]
      end else if (!byte_sel) begin
        data_out = {8'h00, prog_word[23:16]}; // [RULE16]
      end else begin
        data_out = 16'h0000; // [RULE16]
      end
    end
  end
endmodule // word_formatter

// ---- dv/prog_map_asserts.sv ----
// Purpose: Port-level checks for the program-space mapper
// Assumes: One clock, synchronous active-low reset
// Notes: Page registers are internal, so checks key on EA and strobes
module prog_map_asserts (
  input logic ref_clk,
  input logic nrst,
  input logic acc_valid,
  input logic [2:0] acc_kind,
  input logic [15:0] effective_address,
  input logic byte_mode,
  input logic byte_sel,
  input logic move_insn,
  input logic in_repeat,
  input logic pc_advance,
  input logic reg_wr,
  input logic stall,
  input logic prog_rd,
  input logic prog_wr_low,
  input logic prog_wr_high,
  input logic [23:0] prog_addr,
  input logic [23:0] prog_rdata,
  input logic [23:0] fetch_addr,
  input logic data_rd,
  input logic data_wr,
  input logic [15:0] data_addr,
  input logic rd_valid,
  input logic [15:0] rd_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Request accepted at this edge; window read candidate
  wire go = acc_valid && !stall;
  wire win = go && acc_kind == 3'h5 && effective_address[15];
  AST_TBL_ADDR: assert property (go && acc_kind == 3'h1 |=> prog_rd && prog_addr[15:0] == $past(effective_address))
    else $error("table address low half wrong");
  AST_TBL_WORD: assert property (go && acc_kind == 3'h1 && !byte_mode |=> ##1 rd_valid && rd_data == $past(prog_rdata[15:0]))
    else $error("low word read wrong");
  AST_TBL_BYTE: assert property (go && acc_kind == 3'h1 && byte_mode |=> ##1 rd_valid &&
    rd_data[7:0] == ($past(byte_sel, 2) ? $past(prog_rdata[15:8]) : $past(prog_rdata[7:0]))) else $error("low byte wrong");
  AST_TBL_HIGH: assert property (go && acc_kind == 3'h2 |=> ##1 rd_valid && rd_data ==
    {8'h00, ($past(byte_mode, 2) && $past(byte_sel, 2)) ? 8'h00 : $past(prog_rdata[23:16])}) else $error("high read wrong");
  AST_LOW_WR_LANE: assert property (go && acc_kind == 3'h3 |=> !prog_wr_high && !prog_rd)
    else $error("low write touched upper lane");
  AST_WIN_ADDR: assert property (win |=> prog_rd |-> !prog_addr[23] && prog_addr[14:0] == $past(effective_address[14:0]))
    else $error("window address wrong");
  AST_WIN_NO_WRITE: assert property (acc_valid && acc_kind == 3'h6 |=> !prog_wr_low && !prog_wr_high)
    else $error("data write reached program memory");
  AST_STALL_ONE: assert property (win && move_insn && !in_repeat |=> prog_rd |-> stall ##1 !stall)
    else $error("move window stall not one cycle");
  AST_STALL_TWO: assert property (win && !(move_insn && !in_repeat) |=> prog_rd |-> stall[*2] ##1 !stall)
    else $error("window stall not two cycles");
  AST_DATA_LOW: assert property (go && acc_kind == 3'h5 && !effective_address[15] |=>
    data_rd && !prog_rd && data_addr == $past(effective_address)) else $error("lower EA not routed to data");
  AST_DATA_WR_LOW: assert property (go && acc_kind == 3'h6 && !effective_address[15] |=>
    data_wr && !data_rd && data_addr == $past(effective_address)) else $error("lower write not routed to data");
  AST_FETCH_FMT: assert property (!fetch_addr[23] && !fetch_addr[0])
    else $error("fetch address format wrong");
  AST_PC_STEP: assert property (pc_advance && !reg_wr ##1 !reg_wr |=> fetch_addr == $past(fetch_addr) + 24'h2)
    else $error("fetch did not step by two");
endmodule // prog_map_asserts
bind prog_space_mapper prog_map_asserts i_chk (.ref_clk, .nrst, .acc_valid, .acc_kind, .effective_address,
  .byte_mode, .byte_sel, .move_insn, .in_repeat, .pc_advance, .reg_wr, .stall, .prog_rd, .prog_wr_low,
  .prog_wr_high, .prog_addr, .prog_rdata, .fetch_addr, .data_rd, .data_wr, .data_addr, .rd_valid, .rd_data);

// ---- dv/prog_mem_model.sv ----
// Purpose: Program memory on the far side of the mapper, combinational read
// Assumes: Address and read strobe arrive registered from the mapper
// Notes: Outside a read cycle the word is inverted so a late sample shows
module prog_mem_model (
  input logic [23:0] prog_addr,
  input logic prog_rd,
  output logic [23:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contents follow address bits 15:0, so locations differ only within each 64K span
  function automatic logic [23:0] pw(input logic [23:0] a);
    return {a[7:0] ^ 8'h3C, a[15:0] ^ 16'hA55A};
  endfunction
  // Valid only while the read strobe is high
  assign prog_rdata = prog_rd ? pw(prog_addr) : ~pw(prog_addr);
endmodule // prog_mem_model

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the program-space mapper
// Assumes: Combinational program memory model on the far side
// Notes: Expected words come from the memory pattern, never from the design
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, acc_valid = 0, byte_mode = 0, byte_sel = 0;
  logic move_insn = 0, in_repeat = 0, pc_advance = 0, prog_rd, prog_wr_low, prog_wr_high;
  logic data_rd, data_wr, rd_valid, addr_trap, stall, s_rv, s_st;
  logic [1:0] reg_addr = 0;
  logic [2:0] acc_kind = 0;
  logic [5:0] s_f;
  logic [15:0] reg_wdata = 0, effective_address = 0, acc_wdata = 0, reg_rdata, prog_wdata, data_addr, rd_data;
  logic [15:0] got, s_rd, s_pw, s_da, e, m;
  logic [23:0] fetch_addr, prog_addr, prog_rdata, a, w, s_a;
  int fail_count = 0, n_compared = 0, cyc = 0;
  prog_space_mapper i_dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_valid,
    .acc_kind, .effective_address, .byte_mode, .byte_sel, .move_insn, .in_repeat, .acc_wdata, .pc_advance,
    .fetch_addr, .prog_addr, .prog_rd, .prog_wr_low, .prog_wr_high, .prog_wdata, .prog_rdata, .data_addr,
    .data_rd, .data_wr, .rd_data, .rd_valid, .addr_trap, .stall);
  prog_mem_model i_mem (.prog_addr, .prog_rd, .prog_rdata);
  ////////////////////////////////////////////////////////////////////////
  // Same pattern the memory model holds
  function automatic logic [23:0] pw(input logic [23:0] x);
    return {x[7:0] ^ 8'h3C, x[15:0] ^ 16'hA55A};
  endfunction
  initial forever #5 ref_clk = ~ref_clk;
  // Register port: one-cycle strobes, read data in the next cycle only
  task automatic wr(input logic [1:0] r, input logic [15:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'h1, r, d};
    @(posedge ref_clk) reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [1:0] r);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'h1, r};
    @(posedge ref_clk) reg_rd <= 1'h0;
    #1 got = reg_rdata;
  endtask
  // One access; strobes captured a cycle later, result two cycles later
  task automatic acc(input logic [2:0] k, input logic [15:0] ea, input logic bm, bs, mv, rp);
    @(posedge ref_clk);
    {acc_valid, acc_kind, effective_address, byte_mode, byte_sel, move_insn, in_repeat} <= {1'h1, k, ea, bm, bs, mv, rp};
    @(posedge ref_clk) acc_valid <= 1'h0;
    #1 {s_a, s_f, s_pw, s_da} = {prog_addr, prog_rd, prog_wr_low, prog_wr_high, data_rd, addr_trap, stall, prog_wdata, data_addr};
    @(posedge ref_clk) #1 {s_rv, s_rd, s_st} = {rd_valid, rd_data, stall};
    repeat (2) @(posedge ref_clk); // Let any stall run out
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard, well above the roughly 140 cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      rd(i[1:0]);
      `CHK("reg_reset", 16'h0000, got)
    end
    // Table page 0x12: address join, then every read format
    wr(2'h0, 16'h0012);
    w = pw(24'h122468);
    for (int i = 0; i < 8; i++) begin
      acc(i[2] ? 3'h2 : 3'h1, 16'h2468, i[1], i[0], 1'h0, 1'h0);
      `CHK("tbl_addr", {1'h1, 24'h122468}, {s_f[5], s_a})
      e = !i[2] ? (i[1] ? {8'h00, i[0] ? w[15:8] : w[7:0]} : w[15:0]) : {8'h00, (i[1] && i[0]) ? 8'h00 : w[23:16]};
      m = (i[1] && !i[2]) ? 16'h00FF : 16'hFFFF;
      `CHK("tbl_fmt", {1'h1, e & m}, {s_rv, s_rd & m})
    end
    acc_wdata <= 16'hBEEF;
    acc(3'h4, 16'h0020, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("wr_high", {3'h1, 24'h120020, 16'hBEEF}, {s_f[5:3], s_a, s_pw})
    acc(3'h3, 16'h0020, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("wr_low", 3'h2, s_f[5:3])
    // Configuration page: writes dropped and flagged, reads go through
    wr(2'h0, 16'h0080);
    acc(3'h3, 16'h0010, 1'h0, 1'h0, 1'h0, 1'h0);
    acc(3'h4, 16'h0010, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("cfg_wr", 3'h0, s_f[5:3])
    rd(2'h2);
    `CHK("cfg_flag", 1'h1, got[0])
    acc(3'h1, 16'h0010, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("cfg_rd", {1'h1, 24'h800010}, {s_f[5], s_a})
    // Window, upper word, move: one extra cycle
    wr(2'h1, 16'h03A5);
    a = {1'h0, 8'hA5, 15'h4321};
    w = pw(a);
    acc(3'h5, 16'hC321, 1'h0, 1'h0, 1'h1, 1'h0);
    `CHK("win_hi", {6'h21, a, 16'h0 | w[23:16], 1'h0}, {s_f, s_a, s_rd, s_st})
    // Window, lower word, page bit 8 clear, non-move and move in a loop: two extra
    wr(2'h1, 16'h02A4);
    a = {1'h0, 8'hA4, 15'h0321};
    w = pw(a);
    for (int i = 0; i < 2; i++) begin
      acc(3'h5, 16'h8321, 1'h0, 1'h0, i[0], 1'h1);
      `CHK("win_lo", {6'h21, a, w[15:0], 1'h1}, {s_f, s_a, s_rd, s_st})
    end
    acc(3'h6, 16'hC321, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("win_wr", 3'h0, s_f[5:3])
    acc(3'h6, 16'h0123, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("low_wr", {4'h0, 16'h0123}, {s_f[5:2], s_da})
    acc(3'h5, 16'h0456, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("low_ea", {3'h2, 16'h0456}, {s_f[5], s_f[2:1], s_da})
    // Page zero in the upper half traps instead of accessing
    wr(2'h2, 16'h0003);
    wr(2'h1, 16'h0000);
    acc(3'h5, 16'h8000, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("trap", 3'h1, {s_f[5], s_f[2:1]})
    rd(2'h2);
    `CHK("trap_flag", 2'h2, got[1:0])
    // Fetch address from a loaded PC, then two steps
    wr(2'h3, 16'h0010);
    // Fetch address is registered one cycle behind the PC
    @(posedge ref_clk);
    #1 `CHK("fetch", 24'h000020, fetch_addr)
    @(posedge ref_clk) pc_advance <= 1'h1;
    @(posedge ref_clk);
    @(posedge ref_clk) pc_advance <= 1'h0;
    repeat (2) @(posedge ref_clk);
    #1 `CHK("fetch_step", 24'h000024, fetch_addr)
    results();
  end
endmodule // tb
